// file: trp_pkg.sv
// Shared constants, register map and types of the transceiver reset block.
package trp_pkg;
	localparam int NUM_CH = 4;
	localparam int CNT_W = 16;
	localparam int PULSE_W = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MIN_PULSE_CYCLES = 2;
	localparam int PLL_RST_CYCLES = 4;
	localparam int PLL_LOCK_CYCLES = 20;
	localparam int CDR_LOCK_CYCLES = 30;
	localparam int OFFSET_CANCEL_CYCLES = 40;
	localparam int RECONFIG_CYCLES = 16;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_CHAN = 8'h08;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_PWRDN_BIT = 1;
	localparam int CTRL_TXONLY_BIT = 2;
	localparam int CTRL_RECONF_BIT = 3;
	localparam int CTRL_KIND_LSB = 4;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_PLL_BIT = 4;
	localparam int ST_BUSY_BIT = 5;
	localparam int ST_DONE_BIT = 6;
	localparam logic CTRL_PWRDN_RESET = 1'b0;
	localparam logic CTRL_TXONLY_RESET = 1'b0;
	typedef enum logic [1:0] {
		RECONF_ANALOG,
		RECONF_CHANNEL,
		RECONF_PLL,
		RECONF_OFFSET
	} trp_reconf_t;
	typedef enum logic [2:0] {
		S_IDLE,
		S_PLL_RST,
		S_PLL_WAIT,
		S_BUSY_WAIT,
		S_CDR_WAIT,
		S_DONE
	} trp_seq_t;
	typedef enum logic [2:0] {
		B_BOOT,
		B_OFFSET,
		B_IDLE,
		B_RECONF,
		B_PLLRST
	} trp_busy_t;
endpackage

// file: trp_if.sv
// Reset, power-down and status wires between controller and transceiver.
`timescale 1ns/1ps
interface trp_if #(
	parameter int NUM_CH = trp_pkg::NUM_CH
) ();
	logic [NUM_CH-1:0] tx_digital_rst;
	logic [NUM_CH-1:0] rx_digital_rst;
	logic [NUM_CH-1:0] rx_analog_rst;
	logic pll_rst;
	logic block_powerdown;
	logic reconfig_req;
	trp_pkg::trp_reconf_t reconfig_kind;
	logic pll_locked;
	logic busy;
	logic [NUM_CH-1:0] rx_lock_mode;
	modport dev (
		input tx_digital_rst,
		input rx_digital_rst,
		input rx_analog_rst,
		input pll_rst,
		input block_powerdown,
		input reconfig_req,
		input reconfig_kind,
		output pll_locked,
		output busy,
		output rx_lock_mode
	);
	modport ctl (
		output tx_digital_rst,
		output rx_digital_rst,
		output rx_analog_rst,
		output pll_rst,
		output block_powerdown,
		output reconfig_req,
		output reconfig_kind,
		input pll_locked,
		input busy,
		input rx_lock_mode
	);
endinterface

// file: trp_xcvr_dev.sv
// Transceiver end: channel resets, block power-down and status outputs.
// Operation
// - Each channel has its own reset inputs.
// - One power-down covers PLLs and all channels.
// - Resets and power-down act without a clock.
// - Transmit reset clears transmit logic, two cycles.
// - Receive reset clears receive logic, two cycles.
// - Analog reset resets the channel clock recovery.
// - Controller holds analog reset two cycles minimum.
// - Hold digital resets until clocks are stable.
// - Controller pulses PLL reset during reset sequence.
// - PLL reconfiguration raises PLL reset by itself.
// - Power-down stops logic of every channel.
// - Power-down is shared and independent of resets.
// - PLL locked output high when PLL locked.
// - Lock mode high while tracking incoming data.
// - Lock mode low while locked to reference.
// - Busy low first cycle, high from second.
// - Busy high while offset cancellation runs.
// - Busy falls when offset cancellation completes.
// - Busy high for the whole reconfiguration.
// - Transmit reset spares the transmit buffer.
// - Controller waits busy low unless transmit-only.
`timescale 1ns/1ps
module trp_xcvr_dev #(
	parameter int NUM_CH = trp_pkg::NUM_CH
)(
	input wire logic core_clk,
	input wire logic nrst,
	trp_if.dev lnk,
	output logic [NUM_CH-1:0] tx_ready,
	output logic [NUM_CH-1:0] rx_ready,
	output logic [NUM_CH-1:0] pulse_err,
	output logic powered_down
);
	import trp_pkg::*;

	trp_busy_t busy_state;
	trp_reconf_t reconf_kind;
	logic [CNT_W-1:0] busy_cnt;
	logic [CNT_W-1:0] pll_cnt;
	logic pll_auto_rst;
	logic busy;
	logic pll_hold_n;
	logic pll_locked;
	logic [NUM_CH-1:0] lock_mode;

	generate
		if (NUM_CH < 1 || NUM_CH > DATA_W)
		begin : g_bad_ch
			$error("Channel count out of range.");
		end
		if (MIN_PULSE_CYCLES >= (1 << PULSE_W))
		begin : g_bad_pulse
			$error("Pulse counter too narrow.");
		end
	endgenerate

	// The PLL sees the user reset, its own reconfiguration reset and the
	// shared power-down; any of them drops lock at once.
	assign pll_hold_n = nrst & ~lnk.pll_rst & ~pll_auto_rst
		& ~lnk.block_powerdown;

	always_ff @(posedge core_clk or negedge pll_hold_n)
	begin
		if (!pll_hold_n)
		begin
			pll_cnt <= '0;
			pll_locked <= 1'b0;
		end
		else if (pll_cnt == CNT_W'(PLL_LOCK_CYCLES - 1))
		begin
			pll_locked <= 1'b1;
		end
		else
		begin
			pll_cnt <= pll_cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_state <= B_BOOT;
			busy_cnt <= '0;
			busy <= 1'b0;
			reconf_kind <= RECONF_ANALOG;
			pll_auto_rst <= 1'b0;
		end
		else
		begin
			unique case (busy_state)
				B_BOOT:
				begin
					busy <= 1'b1;
					busy_cnt <= CNT_W'(OFFSET_CANCEL_CYCLES - 1);
					busy_state <= B_OFFSET;
				end
				B_OFFSET:
				begin
					if (busy_cnt == '0)
					begin
						busy <= 1'b0;
						busy_state <= B_IDLE;
					end
					else
					begin
						busy_cnt <= busy_cnt - 1'b1;
					end
				end
				B_IDLE:
				begin
					if (lnk.reconfig_req)
					begin
						busy <= 1'b1;
						busy_cnt <= CNT_W'(RECONFIG_CYCLES - 1);
						reconf_kind <= lnk.reconfig_kind;
						busy_state <= B_RECONF;
					end
				end
				B_RECONF:
				begin
					if (busy_cnt != '0)
					begin
						busy_cnt <= busy_cnt - 1'b1;
					end
					else if (reconf_kind == RECONF_PLL)
					begin
						pll_auto_rst <= 1'b1;
						busy_cnt <= CNT_W'(PLL_RST_CYCLES - 1);
						busy_state <= B_PLLRST;
					end
					else
					begin
						busy <= 1'b0;
						busy_state <= B_IDLE;
					end
				end
				B_PLLRST:
				begin
					if (busy_cnt == '0)
					begin
						pll_auto_rst <= 1'b0;
						busy <= 1'b0;
						busy_state <= B_IDLE;
					end
					else
					begin
						busy_cnt <= busy_cnt - 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			powered_down <= 1'b0;
		end
		else
		begin
			powered_down <= lnk.block_powerdown;
		end
	end

	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_ch
		logic tx_hold_n;
		logic rx_hold_n;
		logic cdr_hold_n;
		logic tx_q;
		logic rx_q;
		logic lock_q;
		logic [CNT_W-1:0] cdr_cnt;
		logic [2:0] rst_now;
		logic [2:0] err_q;

		// A channel's own resets, the power-down or nrst clear its logic, and loss of PLL lock clears its clock recovery;
		// the transmit buffer is outside and runs on through a tx reset.
		assign tx_hold_n = nrst & ~lnk.tx_digital_rst[i]
			& ~lnk.block_powerdown;
		assign rx_hold_n = nrst & ~lnk.rx_digital_rst[i]
			& ~lnk.block_powerdown;
		assign cdr_hold_n = nrst & ~lnk.rx_analog_rst[i]
			& ~lnk.block_powerdown & pll_locked;

		always_ff @(posedge core_clk or negedge tx_hold_n)
		begin
			if (!tx_hold_n)
			begin
				tx_q <= 1'b0;
			end
			else
			begin
				tx_q <= 1'b1;
			end
		end

		always_ff @(posedge core_clk or negedge rx_hold_n)
		begin
			if (!rx_hold_n)
			begin
				rx_q <= 1'b0;
			end
			else
			begin
				rx_q <= 1'b1;
			end
		end

		// Clock recovery starts on the reference and moves to the data
		// once it has settled.
		always_ff @(posedge core_clk or negedge cdr_hold_n)
		begin
			if (!cdr_hold_n)
			begin
				cdr_cnt <= '0;
				lock_q <= 1'b0;
			end
			else if (cdr_cnt == CNT_W'(CDR_LOCK_CYCLES - 1))
			begin
				lock_q <= 1'b1;
			end
			else
			begin
				cdr_cnt <= cdr_cnt + 1'b1;
			end
		end

		// The resets come from logic on this same clock, so sampling them
		// here is safe; a pulse shorter than the minimum is only flagged.
		assign rst_now = {lnk.rx_analog_rst[i], lnk.rx_digital_rst[i],
			lnk.tx_digital_rst[i]};

		for (genvar j = 0; j < 3; j++)
		begin : g_pw
			logic [PULSE_W-1:0] width;
			logic err;

			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					width <= '0;
					err <= 1'b0;
				end
				else if (rst_now[j]
					&& width != PULSE_W'(MIN_PULSE_CYCLES))
				begin
					width <= width + 1'b1;
				end
				else if (!rst_now[j] && width != '0)
				begin
					width <= '0;
					if (width < PULSE_W'(MIN_PULSE_CYCLES))
					begin
						err <= 1'b1;
					end
				end
			end
			assign err_q[j] = err;
		end

		assign tx_ready[i] = tx_q;
		assign rx_ready[i] = rx_q;
		assign lock_mode[i] = lock_q;
		assign pulse_err[i] = |err_q;
	end

	assign lnk.pll_locked = pll_locked;
	assign lnk.busy = busy;
	assign lnk.rx_lock_mode = lock_mode;
endmodule // trp_xcvr_dev

// file: trp_rst_ctl.sv
// Controller end: register port and reset sequencing for the transceiver.
`timescale 1ns/1ps
module trp_rst_ctl #(
	parameter int NUM_CH = trp_pkg::NUM_CH
)(
	input wire logic core_clk,
	input wire logic nrst,
	trp_if.ctl lnk,
	input wire logic [trp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [trp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [trp_pkg::DATA_W-1:0] reg_rdata,
	output logic seq_done
);
	import trp_pkg::*;

	trp_seq_t state;
	trp_reconf_t reconf_kind;
	logic [CNT_W-1:0] cnt;
	logic [NUM_CH-1:0] tx_rst;
	logic [NUM_CH-1:0] rx_rst;
	logic [NUM_CH-1:0] ana_rst;
	logic pll_rst;
	logic pwrdn;
	logic tx_only;
	logic start;
	logic reconf_req;
	logic [NUM_CH+1:0] sync1;
	logic [NUM_CH+1:0] sync2;
	logic [NUM_CH+1:0] sync3;
	logic [NUM_CH+1:0] status;
	logic pll_s;
	logic busy_s;
	logic [NUM_CH-1:0] freq_s;

	generate
		if (NUM_CH < 1 || NUM_CH > DATA_W)
		begin : g_bad_ch
			$error("Channel count out of range.");
		end
		if (PLL_RST_CYCLES < MIN_PULSE_CYCLES)
		begin : g_bad_hold
			$error("Reset hold shorter than the minimum pulse.");
		end
	endgenerate

	function automatic logic is_reg(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	// A status bit changes only once two later stages agree, which filters
	// a level caught mid-change.
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			status <= '0;
		end
		else
		begin
			sync1 <= {lnk.pll_locked, lnk.busy, lnk.rx_lock_mode};
			sync2 <= sync1;
			sync3 <= sync2;
			status <= (sync2 & sync3) | (status & (sync2 | sync3));
		end
	end

	assign pll_s = status[NUM_CH+1];
	assign busy_s = status[NUM_CH];
	assign freq_s = status[NUM_CH-1:0];

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwrdn <= CTRL_PWRDN_RESET;
			tx_only <= CTRL_TXONLY_RESET;
			reconf_kind <= RECONF_ANALOG;
			start <= 1'b0;
			reconf_req <= 1'b0;
		end
		else if (reg_wr && is_reg(reg_addr, REG_CTRL))
		begin
			pwrdn <= reg_wdata[CTRL_PWRDN_BIT];
			tx_only <= reg_wdata[CTRL_TXONLY_BIT];
			reconf_kind <= trp_reconf_t'(reg_wdata[CTRL_KIND_LSB +: 2]);
			start <= reg_wdata[CTRL_START_BIT];
			reconf_req <= reg_wdata[CTRL_RECONF_BIT];
		end
		else
		begin
			start <= 1'b0;
			reconf_req <= 1'b0;
		end
	end

	// Every reset is cleared by this clock (nrst sets them at once), so its release is
	// synchronous to the logic it frees.
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= S_IDLE;
			cnt <= '0;
			tx_rst <= '1;
			rx_rst <= '1;
			ana_rst <= '1;
			pll_rst <= 1'b1;
			seq_done <= 1'b0;
		end
		else if (pwrdn)
		begin
			state <= S_IDLE;
			tx_rst <= '1;
			rx_rst <= '1;
			ana_rst <= '1;
			pll_rst <= 1'b1;
			seq_done <= 1'b0;
		end
		else
		begin
			unique case (state)
				S_IDLE, S_DONE:
				begin
					if (start || (state == S_DONE && !pll_s))
					begin
						cnt <= CNT_W'(PLL_RST_CYCLES - 1);
						tx_rst <= '1;
						rx_rst <= '1;
						ana_rst <= '1;
						pll_rst <= 1'b1;
						seq_done <= 1'b0;
						state <= S_PLL_RST;
					end
				end
				S_PLL_RST:
				begin
					if (cnt == '0)
					begin
						pll_rst <= 1'b0;
						state <= S_PLL_WAIT;
					end
					else
					begin
						cnt <= cnt - 1'b1;
					end
				end
				S_PLL_WAIT:
				begin
					if (pll_s)
					begin
						tx_rst <= '0;
						if (tx_only)
						begin
							seq_done <= 1'b1;
							state <= S_DONE;
						end
						else
						begin
							state <= S_BUSY_WAIT;
						end
					end
				end
				S_BUSY_WAIT:
				begin
					if (!busy_s)
					begin
						ana_rst <= '0;
						state <= S_CDR_WAIT;
					end
				end
				S_CDR_WAIT:
				begin
					if (&freq_s)
					begin
						rx_rst <= '0;
						seq_done <= 1'b1;
						state <= S_DONE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata <= '0;
		end
		else
		begin
			reg_rdata <= '0;
			if (reg_rd && is_reg(reg_addr, REG_CTRL))
			begin
				reg_rdata[CTRL_PWRDN_BIT] <= pwrdn;
				reg_rdata[CTRL_TXONLY_BIT] <= tx_only;
				reg_rdata[CTRL_KIND_LSB +: 2] <= reconf_kind;
			end
			else if (reg_rd && is_reg(reg_addr, REG_STATUS))
			begin
				reg_rdata[ST_STATE_LSB +: 3] <= state;
				reg_rdata[ST_PLL_BIT] <= pll_s;
				reg_rdata[ST_BUSY_BIT] <= busy_s;
				reg_rdata[ST_DONE_BIT] <= seq_done;
			end
			else if (reg_rd && is_reg(reg_addr, REG_CHAN))
			begin
				reg_rdata[NUM_CH-1:0] <= freq_s;
			end
		end
	end

	assign lnk.tx_digital_rst = tx_rst;
	assign lnk.rx_digital_rst = rx_rst;
	assign lnk.rx_analog_rst = ana_rst;
	assign lnk.pll_rst = pll_rst;
	assign lnk.block_powerdown = pwrdn;
	assign lnk.reconfig_req = reconf_req;
	assign lnk.reconfig_kind = reconf_kind;
endmodule // trp_rst_ctl

// file: trp_sva.sv
// Assertions on the link between the controller and transceiver ends.
`timescale 1ns/1ps
module trp_sva
	import trp_pkg::*;
#(
	parameter int NUM_CH = trp_pkg::NUM_CH
)(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [NUM_CH-1:0] tx_digital_rst,
	input wire logic [NUM_CH-1:0] rx_digital_rst,
	input wire logic [NUM_CH-1:0] rx_analog_rst,
	input wire logic pll_rst,
	input wire logic block_powerdown,
	input wire logic reconfig_req,
	input wire logic [1:0] reconfig_kind,
	input wire logic pll_locked,
	input wire logic busy,
	input wire logic [NUM_CH-1:0] rx_lock_mode
);
	import trp_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	sequence s_boot;
		!busy ##1 busy[*8];
	endsequence
	sequence s_pll_pulse;
		pll_rst[*4] ##1 !pll_rst;
	endsequence
	property p_busy_boot;
		$rose(nrst) |-> s_boot;
	endproperty
	a_busy_boot: assert property (p_busy_boot)
		else $error("busy start order wrong");
	property p_offset_end;
		$rose(nrst) |-> ##[40:42] !busy;
	endproperty
	a_offset_end: assert property (p_offset_end)
		else $error("offset busy did not end");
	property p_reconf;
		reconfig_req && !busy |=> busy[*8];
	endproperty
	a_reconf: assert property (p_reconf)
		else $error("busy not held in reconfig");
	property p_pll_drop;
		pll_rst |=> !pll_locked;
	endproperty
	a_pll_drop: assert property (p_pll_drop)
		else $error("lock kept under pll reset");
	// Powerdown also asserts the PLL reset, so only clean starts are judged.
	property p_pll_pulse;
		$rose(pll_rst) && !block_powerdown |-> s_pll_pulse;
	endproperty
	a_pll_pulse: assert property (p_pll_pulse)
		else $error("pll reset pulse length wrong");
	property p_tx_pulse;
		$fell(tx_digital_rst[0]) |-> $past(tx_digital_rst[0], 2);
	endproperty
	a_tx_pulse: assert property (p_tx_pulse)
		else $error("tx reset pulse too short");
	property p_rx_pulse;
		$fell(rx_digital_rst[0]) |-> $past(rx_digital_rst[0], 2);
	endproperty
	a_rx_pulse: assert property (p_rx_pulse)
		else $error("rx reset pulse too short");
	property p_ana_pulse;
		$fell(rx_analog_rst[0]) |-> $past(rx_analog_rst[0], 2);
	endproperty
	a_ana_pulse: assert property (p_ana_pulse)
		else $error("analog reset pulse too short");
	property p_tx_lock;
		$fell(tx_digital_rst[0]) |-> pll_locked;
	endproperty
	a_tx_lock: assert property (p_tx_lock)
		else $error("tx released before lock");
	property p_rx_ltd;
		$fell(rx_digital_rst[0]) |-> &rx_lock_mode;
	endproperty
	a_rx_ltd: assert property (p_rx_ltd)
		else $error("rx released before data lock");
	property p_ana_busy;
		$fell(rx_analog_rst[0]) |-> !busy;
	endproperty
	a_ana_busy: assert property (p_ana_busy)
		else $error("analog released while busy");
	property p_ltd_clear;
		|rx_analog_rst |=> (rx_lock_mode & $past(rx_analog_rst)) == '0;
	endproperty
	a_ltd_clear: assert property (p_ltd_clear)
		else $error("lock mode kept under analog reset");
	property p_pwdn;
		block_powerdown |-> ##2 !pll_locked && rx_lock_mode == '0;
	endproperty
	a_pwdn: assert property (p_pwdn)
		else $error("status alive in powerdown");
	property p_ltd_rise;
		$rose(rx_lock_mode[0]) |-> pll_locked && !rx_analog_rst[0];
	endproperty
	a_ltd_rise: assert property (p_ltd_rise)
		else $error("data lock without pll lock");
endmodule // trp_sva

// file: transceiver_reset_powerdown_control_bench.sv
// Self-checking bench joining the controller and transceiver ends.
`timescale 1ns/1ps
module transceiver_reset_powerdown_control_bench;
	import trp_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic seq_done;
	logic [NUM_CH-1:0] tx_ready;
	logic [NUM_CH-1:0] rx_ready;
	logic [NUM_CH-1:0] pulse_err;
	logic powered_down;
	int failures = 0;
	int compares = 0;
	always #5 core_clk = ~core_clk;
	trp_if #(.NUM_CH(NUM_CH)) lnk ();
	trp_xcvr_dev #(.NUM_CH(NUM_CH)) u_trp_xcvr_dev (.core_clk(core_clk),
		.nrst(nrst), .lnk(lnk.dev), .tx_ready(tx_ready),
		.rx_ready(rx_ready), .pulse_err(pulse_err),
		.powered_down(powered_down));
	trp_rst_ctl #(.NUM_CH(NUM_CH)) u_trp_rst_ctl (.core_clk(core_clk),
		.nrst(nrst), .lnk(lnk.ctl), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .seq_done(seq_done));
	trp_sva #(.NUM_CH(NUM_CH)) u_trp_sva (.core_clk(core_clk), .nrst(nrst),
		.tx_digital_rst(lnk.tx_digital_rst),
		.rx_digital_rst(lnk.rx_digital_rst),
		.rx_analog_rst(lnk.rx_analog_rst), .pll_rst(lnk.pll_rst),
		.block_powerdown(lnk.block_powerdown),
		.reconfig_req(lnk.reconfig_req), .reconfig_kind(lnk.reconfig_kind),
		.pll_locked(lnk.pll_locked), .busy(lnk.busy),
		.rx_lock_mode(lnk.rx_lock_mode));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so look there.
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, e);
	endtask
	task automatic wait_for(input bit on_busy, input logic v, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			@(posedge core_clk);
			#1;
			if ((on_busy ? lnk.busy : seq_done) === v)
				return;
		end
		failures++;
		$display("MISMATCH t=%0t wait expired", $time);
		tally_and_finish();
	endtask
	initial
	begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		rd(REG_CHAN, 32'hFFFFFFFF, 32'h0);
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		chk(32'({tx_ready, rx_ready}), 32'h0);
		wr(REG_CTRL, 32'h1);
		wait_for(0, 1'b1, 400);
		// A ready flag rises on the edge after its reset is released.
		@(posedge core_clk);
		#1;
		chk(32'({tx_ready, rx_ready, pulse_err}), 32'hFF0);
		rd(REG_CHAN, 32'hF, 32'hF);
		rd(REG_STATUS, 32'h7F, 32'h55);
		for (int k = 0; k < 4; k++)
		begin
			wr(REG_CTRL, 32'h8 | (32'(k) << 4));
			wait_for(1, 1'b1, 4);
			if (k == 2)
				wait_for(0, 1'b0, 30);
			wait_for(1, 1'b0, 40);
			wait_for(0, 1'b1, 200);
			chk(32'(seq_done), 32'h1);
		end
		wr(REG_CTRL, 32'h4);
		wr(REG_CTRL, 32'h5);
		wait_for(0, 1'b0, 4);
		wait_for(0, 1'b1, 200);
		@(posedge core_clk);
		#1;
		chk(32'({tx_ready, rx_ready}), 32'hF0);
		rd(REG_CHAN, 32'hF, 32'h0);
		wr(REG_CTRL, 32'h2);
		repeat (3) @(posedge core_clk);
		#1;
		chk(32'({powered_down, tx_ready, rx_ready, seq_done}), 32'h200);
		rd(REG_STATUS, 32'h7, 32'h0);
		wr(REG_CTRL, 32'h0);
		wr(REG_CTRL, 32'h1);
		wait_for(0, 1'b1, 400);
		@(posedge core_clk);
		#1;
		chk(32'({tx_ready, rx_ready}), 32'hFF);
		@(posedge core_clk);
		nrst <= 1'b0;
		#1;
		chk(32'({tx_ready, rx_ready, lnk.busy}), 32'h0);
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		wr(REG_CTRL, 32'h1);
		wait_for(0, 1'b1, 400);
		chk(32'(pulse_err), 32'h0);
		tally_and_finish();
	end
endmodule // transceiver_reset_powerdown_control_bench
